// ### verilog/periph_clock_gate_and_reset_cause.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defs.svh"
module periph_clock_gate_and_reset_cause
  import pm_pkg::*;
#(
  parameter logic [15:0] SETTLE_CYCLES = 16'(`SETTLE_CYCLES)
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // divider selections from the clock generator
  input wire logic [2:0] CPU_DIV_SEL,
  input wire logic [2:0] BUS_DIV_SEL,
  // reset source record from the reset controller
  input wire reset_src_s RESET_SRC,
  // gated clock enables and interrupt
  output bus_c_gate_s GATE_EN,
  output logic IRQ
);

  localparam state_s STATE_RST = '{
    mask: `BUS_C_MASK_RST,
    ien: `IRQ_EN_RST,
    flag: `IRQ_FLAG_RST,
    cause: `RESET_CAUSE_RST,
    wp: `WRITE_PROTECT_RST,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    irq: 1'b0,
    fsm: SETTLE_IDLE,
    cnt: 16'h0000,
    cpu_sel: 3'h0,
    bus_sel: 3'h0,
    capture: 1'b1
  };

  state_s s_r;
  state_s s_n;
  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic wr_do;
  logic wr_prot;
  logic ien_clr;
  logic ien_set;
  logic flag_clr;
  logic ready_set;
  logic sel_moved;
  logic [31:0] rd_word;

  // decoded strobes and divider compares
  logic wr_mask;
  logic wr_wp;
  logic cpu_moved;
  logic bus_moved;

  // mapped register indices
  function automatic logic reg_hit(input logic [7:0] i);
    case (i)
      `IDX_BUS_C_MASK: reg_hit = 1'b1;
      `IDX_IRQ_EN_CLR: reg_hit = 1'b1;
      `IDX_IRQ_EN_SET: reg_hit = 1'b1;
      `IDX_IRQ_FLAG: reg_hit = 1'b1;
      `IDX_RESET_CAUSE: reg_hit = 1'b1;
      `IDX_WRITE_PROTECT: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // byte-lane merge limited to implemented bits
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb,
                                              input logic [31:0] writable);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge_lanes = m & writable;
  endfunction

  // one-hot pick of the latest source, power-on first
  function automatic logic [7:0] cause_encode(input reset_src_s src);
    logic [7:0] c;
    c = 8'h00;
    if (src.power_on_reset_flag) begin
      c[`BIT_CAUSE_POR] = 1'b1;
    end else if (src.brownout_1v2_reset_flag) begin
      c[`BIT_CAUSE_BROWNOUT_1V2_RESET_FLAG] = 1'b1;
    end else if (src.brownout_3v3_reset_flag) begin
      c[`BIT_CAUSE_BROWNOUT_3V3_RESET_FLAG] = 1'b1;
    end else if (src.outside_pin_reset_flag) begin
      c[`BIT_CAUSE_EXT] = 1'b1;
    end else if (src.watchdog_reset_flag) begin
      c[`BIT_CAUSE_WDT] = 1'b1;
    end else if (src.software_reset_request_flag) begin
      c[`BIT_CAUSE_SOFTWARE_RESET_REQUEST_FLAG] = 1'b1;
    end else begin
      c = `RESET_CAUSE_RST;
    end
    cause_encode = c;
  endfunction

  // bit 0 of an 8-bit register written with a one
  function automatic logic lane0_one(input logic [3:0] strb, input logic [31:0] wd);
    lane0_one = strb[0] && wd[`BIT_CLOCK_READY];
  endfunction

  // counter preset; a zero setting still waits one edge
  function automatic logic [15:0] settle_load(input logic [15:0] cycles);
    if (cycles == 16'h0000) begin
      settle_load = 16'h0000;
    end else begin
      settle_load = cycles - 16'h0001;
    end
  endfunction

  // latch the selections that the running settle count refers to
  function automatic state_s sel_latch(input state_s st, input logic [2:0] cpu,
                                       input logic [2:0] bus);
    sel_latch = st;
    sel_latch.cpu_sel = cpu;
    sel_latch.bus_sel = bus;
  endfunction

  // mask bits to per-peripheral bus clock enables
  function automatic bus_c_gate_s gates_of(input logic [31:0] m);
    bus_c_gate_s g;
    // analog
    g.touch_controller_clk_en = m[19]; // RULE1
    g.dac_clk_en = m[18]; // RULE1
    g.comparator_clk_en = m[17]; // RULE1
    g.adc_clk_en = m[16]; // RULE1
    // timers
    g.timer_7_clk_en = m[15]; // RULE2
    g.timer_6_clk_en = m[14]; // RULE2
    g.timer_5_clk_en = m[13]; // RULE2
    g.timer_4_clk_en = m[12]; // RULE2
    g.timer_3_clk_en = m[11]; // RULE2
    g.ctrl_timer_2_clk_en = m[10]; // RULE2
    g.ctrl_timer_1_clk_en = m[9]; // RULE2
    g.ctrl_timer_0_clk_en = m[8]; // RULE2
    // serial units
    g.serial_unit_5_clk_en = m[7]; // RULE3
    g.serial_unit_4_clk_en = m[6]; // RULE3
    g.serial_unit_3_clk_en = m[5]; // RULE3
    g.serial_unit_2_clk_en = m[4]; // RULE3
    g.serial_unit_1_clk_en = m[3]; // RULE3
    g.serial_unit_0_clk_en = m[2]; // RULE3
    // system
    g.event_router_clk_en = m[1]; // RULE4
    g.access_guard_2_clk_en = m[0]; // RULE4
    gates_of = g;
  endfunction

  // enables back to a bus word; bits 31:20 read zero
  function automatic logic [31:0] word_of(input bus_c_gate_s g);
    logic [31:0] w;
    w = 32'h0000_0000;
    // analog
    w[19] = g.touch_controller_clk_en;
    w[18] = g.dac_clk_en;
    w[17] = g.comparator_clk_en;
    w[16] = g.adc_clk_en;
    // timers
    w[15] = g.timer_7_clk_en;
    w[14] = g.timer_6_clk_en;
    w[13] = g.timer_5_clk_en;
    w[12] = g.timer_4_clk_en;
    w[11] = g.timer_3_clk_en;
    w[10] = g.ctrl_timer_2_clk_en;
    w[9] = g.ctrl_timer_1_clk_en;
    w[8] = g.ctrl_timer_0_clk_en;
    // serial units
    w[7] = g.serial_unit_5_clk_en;
    w[6] = g.serial_unit_4_clk_en;
    w[5] = g.serial_unit_3_clk_en;
    w[4] = g.serial_unit_2_clk_en;
    w[3] = g.serial_unit_1_clk_en;
    w[2] = g.serial_unit_0_clk_en;
    // system
    w[1] = g.event_router_clk_en;
    w[0] = g.access_guard_2_clk_en;
    word_of = w;
  endfunction

  // both enable registers show the one shared enable
  function automatic logic [31:0] en_word(input logic e);
    en_word = 32'h0000_0000;
    en_word[0] = e; // RULE6
  endfunction

  // unused bits 3 and 7 never read back set
  function automatic logic [7:0] cause_clean(input logic [7:0] c);
    cause_clean = c;
    cause_clean[3] = 1'b0;
    cause_clean[7] = 1'b0;
  endfunction

  // read mux; reserved bits read zero
  function automatic logic [31:0] read_word(input state_s st, input logic [7:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      `IDX_BUS_C_MASK: w = word_of(gates_of(st.mask));
      `IDX_IRQ_EN_CLR: w = en_word(st.ien); // RULE6
      `IDX_IRQ_EN_SET: w = en_word(st.ien); // RULE6
      `IDX_IRQ_FLAG: w[`BIT_CLOCK_READY] = st.flag; // RULE9
      `IDX_RESET_CAUSE: w[7:0] = cause_clean(st.cause); // RULE10 RULE17
      `IDX_WRITE_PROTECT: w[0] = st.wp;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  always_comb begin
    s_n = s_r;
    idx = PADDR[9:2];
    aligned = (PADDR[1:0] == 2'b00);
    setup = PSEL && !PENABLE && !s_r.ready;
    wr_do = PSEL && PENABLE && PWRITE && s_r.ready && !s_r.slverr;
    wr_prot = wr_do && !s_r.wp; // RULE18
    ien_clr = 1'b0;
    ien_set = 1'b0;
    flag_clr = 1'b0;
    ready_set = 1'b0;
    sel_moved = 1'b0;

    rd_word = read_word(s_r, idx);

    // write strobes
    wr_mask = wr_prot && (idx == `IDX_BUS_C_MASK);
    wr_wp = wr_do && (idx == `IDX_WRITE_PROTECT) && PSTRB[0];

    // divider compares against the latched selections
    cpu_moved = (CPU_DIV_SEL != s_r.cpu_sel);
    bus_moved = (BUS_DIV_SEL != s_r.bus_sel);

    // one wait-free access phase per transfer
    s_n.ready = setup;
    if (setup) begin
      s_n.slverr = !(aligned && reg_hit(idx));
      s_n.rdata = (aligned && !PWRITE) ? rd_word : 32'h0000_0000;
    end else begin
      s_n.slverr = 1'b0;
      s_n.rdata = 32'h0000_0000;
    end

    // clock mask, reset cause stays read-only
    if (wr_mask) begin
      s_n.mask = merge_lanes(s_r.mask, PWDATA, PSTRB, `BUS_C_MASK_WRITABLE); // RULE1 RULE2 RULE3 RULE4
    end

    if (wr_prot && lane0_one(PSTRB, PWDATA)) begin
      ien_clr = (idx == `IDX_IRQ_EN_CLR);
      ien_set = (idx == `IDX_IRQ_EN_SET);
    end
    if (ien_clr) begin
      s_n.ien = 1'b0; // RULE5
    end
    if (ien_set) begin
      s_n.ien = 1'b1; // RULE6
    end

    flag_clr = wr_do && idx == `IDX_IRQ_FLAG && lane0_one(PSTRB, PWDATA); // RULE9 RULE18

    if (wr_wp) begin
      s_n.wp = PWDATA[0];
    end

    // divider change tracking
    sel_moved = !s_r.capture && (cpu_moved || bus_moved);
    unique case (s_r.fsm)
      SETTLE_IDLE: begin
        if (sel_moved) begin
          s_n.fsm = SETTLE_WAIT;
          s_n.cnt = settle_load(SETTLE_CYCLES);
          s_n = sel_latch(s_n, CPU_DIV_SEL, BUS_DIV_SEL);
        end
      end
      SETTLE_WAIT: begin
        if (sel_moved) begin
          s_n.cnt = settle_load(SETTLE_CYCLES);
          s_n = sel_latch(s_n, CPU_DIV_SEL, BUS_DIV_SEL);
        end else if (s_r.cnt == 16'h0000) begin
          ready_set = 1'b1; // RULE8
          s_n.fsm = SETTLE_IDLE;
        end else begin
          s_n.cnt = s_r.cnt - 16'h0001;
        end
      end
      default: begin
        s_n.fsm = SETTLE_IDLE;
        s_n.cnt = 16'h0000;
      end
    endcase

    // set beats a clear in the same cycle
    s_n.flag = (s_r.flag && !flag_clr) || ready_set; // RULE8 RULE9
    s_n.irq = s_n.flag && s_n.ien; // RULE7 RULE5

    // first enabled cycle after reset release
    if (s_r.capture) begin
      s_n.cause = cause_encode(RESET_SRC); // RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE17
      s_n = sel_latch(s_n, CPU_DIV_SEL, BUS_DIV_SEL);
      s_n.capture = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_r <= STATE_RST; // RULE16 RULE9 RULE10
    end else if (CE) begin
      s_r <= s_n;
    end
  end

  assign PRDATA = s_r.rdata;
  assign PREADY = s_r.ready;
  assign PSLVERR = s_r.slverr;
  assign GATE_EN = gates_of(s_r.mask); // RULE1 RULE2 RULE3 RULE4
  assign IRQ = s_r.irq;

endmodule
`default_nettype wire

// ### pkg/pm_defs.svh
// Contract
// RULE1: mask bits 16-19 gate adc, comparator, dac and touch clocks; 0 stops, 1 runs
// RULE2: mask bits 8-15 gate control timers 0-2 and basic timers 3-7
// RULE3: mask bits 2-7 gate serial units 0 to 5 in ascending order
// RULE4: mask bit 1 gates event router, bit 0 gates access guard 2
// RULE5: writing one to enable-clear bit 0 drops enable and pending request
// RULE6: writing one to enable-set bit 0 sets enable; both read same state
// RULE7: interrupt request high while clock-ready flag and its enable are set
// RULE8: clock-ready flag sets once clocks settle to current divider selections
// RULE9: writing one clears clock-ready flag; zero no effect; flag resets to 0x00
// RULE10: reset cause is read-only and reads 0x01 after power-on reset
// RULE11: reset cause bit 6 marks a processor system reset request
// RULE12: reset cause bit 5 marks a watchdog timeout reset
// RULE13: reset cause bit 4 marks an external reset pin reset
// RULE14: reset cause bit 2 marks a 3.3 V brown-out reset
// RULE15: reset cause bit 1 marks a 1.2 V brown-out reset
// RULE16: clock mask resets to 0x00010000, only adc clock running
// RULE17: each reset reloads cause with only the latest source; bits 3, 7 zero
// RULE18: write protection blocks mask and enable writes, never flag writes
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH

`define CLK_PERIOD_NS 20

// register indices; byte address is four times the index
`define IDX_BUS_C_MASK 8'h20
`define IDX_IRQ_EN_CLR 8'h34
`define IDX_IRQ_EN_SET 8'h35
`define IDX_IRQ_FLAG 8'h36
`define IDX_RESET_CAUSE 8'h38
`define IDX_WRITE_PROTECT 8'h3c

// reset values
`define BUS_C_MASK_RST 32'h0001_0000
`define IRQ_EN_RST 1'b0
`define IRQ_FLAG_RST 1'b0
`define RESET_CAUSE_RST 8'h01
`define WRITE_PROTECT_RST 1'b0

// field layout
`define BUS_C_GATE_W 20
`define BUS_C_MASK_WRITABLE 32'h000f_ffff
`define BIT_CLOCK_READY 0
`define BIT_CAUSE_POR 0
`define BIT_CAUSE_BROWNOUT_1V2_RESET_FLAG 1
`define BIT_CAUSE_BROWNOUT_3V3_RESET_FLAG 2
`define BIT_CAUSE_EXT 4
`define BIT_CAUSE_WDT 5
`define BIT_CAUSE_SOFTWARE_RESET_REQUEST_FLAG 6

// clock settling after a divider change
`define SETTLE_NS 200
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### pkg/pm_pkg.sv
`default_nettype none
package pm_pkg;

  typedef struct packed {
    logic touch_controller_clk_en;
    logic dac_clk_en;
    logic comparator_clk_en;
    logic adc_clk_en;
    logic timer_7_clk_en;
    logic timer_6_clk_en;
    logic timer_5_clk_en;
    logic timer_4_clk_en;
    logic timer_3_clk_en;
    logic ctrl_timer_2_clk_en;
    logic ctrl_timer_1_clk_en;
    logic ctrl_timer_0_clk_en;
    logic serial_unit_5_clk_en;
    logic serial_unit_4_clk_en;
    logic serial_unit_3_clk_en;
    logic serial_unit_2_clk_en;
    logic serial_unit_1_clk_en;
    logic serial_unit_0_clk_en;
    logic event_router_clk_en;
    logic access_guard_2_clk_en;
  } bus_c_gate_s;

  typedef struct packed {
    logic software_reset_request_flag;
    logic watchdog_reset_flag;
    logic outside_pin_reset_flag;
    logic brownout_3v3_reset_flag;
    logic brownout_1v2_reset_flag;
    logic power_on_reset_flag;
  } reset_src_s;

  typedef enum logic [1:0] {
    SETTLE_IDLE = 2'b01,
    SETTLE_WAIT = 2'b10
  } settle_e;

  typedef struct packed {
    logic [31:0] mask;
    logic ien;
    logic flag;
    logic [7:0] cause;
    logic wp;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    settle_e fsm;
    logic [15:0] cnt;
    logic [2:0] cpu_sel;
    logic [2:0] bus_sel;
    logic capture;
  } state_s;

endpackage
`default_nettype wire

// ### test/pm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pm_asserts
  import pm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // outputs
  input wire bus_c_gate_s GATE_EN,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  wire logic acc = PSEL && PENABLE && PREADY && PWRITE;
  // write protection as last written on the bus
  logic wp_seen;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wp_seen <= 1'b0;
    end else if (CE && acc && PADDR == 10'h0f0) begin
      wp_seen <= PWDATA[0];
    end
  end
  a_gate_reset: assert property ($past(SRST) |-> GATE_EN == 20'h10000)
    else $error("gate reset value");
  a_gate_write: assert property (!$stable(GATE_EN) && !$past(SRST) |->
    $past(acc && PADDR == 10'h080)) else $error("gate moved");
  a_clr_drops_irq: assert property (acc && !wp_seen && PADDR == 10'h0d0 && PWDATA[0] |=> !IRQ)
    else $error("irq after clear");
  a_flag_drops_irq: assert property (acc && PADDR == 10'h0d8 && PWDATA[0] |=> !IRQ)
    else $error("irq after flag clear");
  a_irq_holds: assert property (IRQ && !acc |=> IRQ)
    else $error("irq dropped");
  a_ready_after: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("no ready");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("rdata idle");
  a_err_align: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("no slverr");
  cover property ($rose(IRQ));
  cover property ($fell(IRQ));
  cover property (PREADY && PSLVERR);
endmodule
bind periph_clock_gate_and_reset_cause pm_asserts chk_u (.CLK, .SRST, .CE, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .GATE_EN, .IRQ);
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pm_pkg::*;
  logic CLK = 0, SRST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [9:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, r;
  logic [3:0] PSTRB = 4'hf;
  logic PREADY, PSLVERR, IRQ, e;
  logic [2:0] CPU_DIV_SEL = '0, BUS_DIV_SEL = '0;
  reset_src_s RESET_SRC = 6'h01;
  bus_c_gate_s GATE_EN;
  int fails = 0, comparisons = 0;
  periph_clock_gate_and_reset_cause #(.SETTLE_CYCLES(16'h2)) dut_u (.CLK, .SRST, .CE,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
    .CPU_DIV_SEL, .BUS_DIV_SEL, .RESET_SRC, .GATE_EN, .IRQ);
  initial begin
    forever #10 CLK = ~CLK;
  end
  task test_done;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task rst(input logic [5:0] src);
    @(posedge CLK);
    SRST <= 1;
    RESET_SRC <= src;
    repeat (4) @(posedge CLK);
    SRST <= 0;
    repeat (2) @(posedge CLK);
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1 && n < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    #1;
    if (n == 20) begin
      chk(0, 1);
      test_done;
    end
  endtask
  task rd(input logic [9:0] a, input logic [31:0] x);
    apb(0, a, '0);
    chk(r, x);
  endtask
  task wait_irq;
    for (int n = 0; n < 50 && IRQ !== 1; n++) @(posedge CLK);
    #1;
    chk(IRQ, 1);
    if (IRQ !== 1) test_done;
  endtask
  task t_reset;
    chk(GATE_EN, 32'h10000);
    rd(10'h080, 32'h10000);
    rd(10'h0d8, 32'h0);
    rd(10'h0e0, 32'h1);
    $display("done reset");
  endtask
  task t_mask;
    for (int i = 0; i < 20; i++) begin
      apb(1, 10'h080, 32'h1 << i);
      chk(GATE_EN, 32'h1 << i);
    end
    apb(1, 10'h080, 32'h0008_0105);
    chk({GATE_EN.touch_controller_clk_en, GATE_EN.ctrl_timer_0_clk_en,
      GATE_EN.serial_unit_0_clk_en, GATE_EN.access_guard_2_clk_en}, 32'hf);
    apb(1, 10'h080, 32'hffff_ffff);
    rd(10'h080, 32'h000f_ffff);
    $display("done mask");
  endtask
  task t_wp;
    apb(1, 10'h0f0, 32'h1);
    apb(1, 10'h080, 32'h0);
    rd(10'h080, 32'h000f_ffff);
    apb(1, 10'h0d4, 32'h1);
    rd(10'h0d4, 32'h0);
    apb(1, 10'h0f0, 32'h0);
    apb(1, 10'h0e0, 32'hff);
    rd(10'h0e0, 32'h1);
    rd(10'h082, 32'h0);
    chk(e, 1);
    rd(10'h3fc, 32'h0);
    chk(e, 1);
    $display("done protect");
  endtask
  task t_irq;
    apb(1, 10'h0d4, 32'h1);
    rd(10'h0d0, 32'h1);
    chk(IRQ, 0);
    @(posedge CLK);
    CPU_DIV_SEL <= 3'h3;
    wait_irq;
    apb(1, 10'h0d8, 32'h0);
    chk(IRQ, 1);
    apb(1, 10'h0d0, 32'h1);
    chk(IRQ, 0);
    rd(10'h0d4, 32'h0);
    apb(1, 10'h0d4, 32'h1);
    chk(IRQ, 1);
    apb(1, 10'h0d8, 32'h1);
    rd(10'h0d8, 32'h0);
    chk(IRQ, 0);
    @(posedge CLK);
    BUS_DIV_SEL <= 3'h5;
    wait_irq;
    rd(10'h0d8, 32'h1);
    $display("done irq");
  endtask
  task t_cause;
    logic [7:0] x [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
    for (int k = 1; k < 6; k++) begin
      rst(6'h1 << k);
      rd(10'h0e0, x[k-1]);
    end
    rst(6'h3f);
    rd(10'h0e0, 32'h1);
    $display("done cause");
  endtask
  initial begin
    rst(6'h01);
    t_reset;
    t_mask;
    t_wp;
    t_irq;
    t_cause;
    test_done;
  end
endmodule
`default_nettype wire
